/* drive_speed_command_select.sv */
// Frequency command selection from jog, up/down, three-wire and dwell
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Jog input runs at jog frequency over all sources except dwell.
// - Function code 4 makes a terminal the jog input.
// - Jog frequency is held between start and maximum frequency.
// - Codes 26 and 27 give forward and reverse jog.
// - Up/down source only acts when setting method is 8.
// - Code 15 is frequency increase, code 16 frequency decrease.
// - Code 25 clears the stored up/down frequency.
// - With save enabled, frequency before stop or deceleration is stored.
// - Clear is ignored while increase or decrease is active.
// - Mode 0 ramps up to max or high limit, down to zero or low limit.
// - Mode 1 steps per rising edge; saves at falling edge.
// - Mode 1 stop keeps last falling edge value; no save otherwise.
// - Mode 2 steps on edge, ramps continuously after 3 s held.
// - All modes share the ramp rate; step comes from step frequency.
// - Edges during a step are ignored; save value at release.
// - Code 17 enables three-wire control with latched run pulses.
// - Run start holds dwell frequency for dwell time, then accelerates.
// - No command passes above the maximum frequency.
// - A command below start frequency becomes zero.
module drive_speed_command_select #(
  parameter int TICK_CYCLES = speed_cmd_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic input_terminal_1,
  input wire logic input_terminal_2,
  input wire logic input_terminal_3,
  input wire logic input_terminal_4,
  input wire logic forward_run,
  input wire logic [speed_cmd_pkg::FUNC_W-1:0] terminal1_function,
  input wire logic [speed_cmd_pkg::FUNC_W-1:0] terminal2_function,
  input wire logic [speed_cmd_pkg::FUNC_W-1:0] terminal3_function,
  input wire logic [speed_cmd_pkg::FUNC_W-1:0] terminal4_function,
  input wire logic [3:0] freq_setting_method,
  input wire logic [speed_cmd_pkg::FREQ_W-1:0] base_ref_freq,
  input wire logic [speed_cmd_pkg::FREQ_W-1:0] jog_freq_setting,
  input wire logic [speed_cmd_pkg::FREQ_W-1:0] max_freq_setting,
  input wire logic [speed_cmd_pkg::FREQ_W-1:0] start_freq_setting,
  input wire logic freq_limit_enable,
  input wire logic [speed_cmd_pkg::FREQ_W-1:0] freq_high_limit,
  input wire logic [speed_cmd_pkg::FREQ_W-1:0] freq_low_limit,
  input wire logic updown_save_enable,
  input wire logic [1:0] updown_mode_select,
  input wire logic [speed_cmd_pkg::FREQ_W-1:0] updown_step_freq,
  input wire logic [speed_cmd_pkg::FREQ_W-1:0] updown_ramp_rate,
  input wire logic [speed_cmd_pkg::FREQ_W-1:0] dwell_freq,
  input wire logic [speed_cmd_pkg::DWELL_TIME_W-1:0] dwell_time,
  output logic [speed_cmd_pkg::FREQ_W-1:0] freq_command,
  output logic reverse_dir,
  output logic run_active,
  output logic dwell_active,
  output logic jog_active,
  output logic [speed_cmd_pkg::FREQ_W-1:0] updown_freq,
  output logic [speed_cmd_pkg::FREQ_W-1:0] updown_saved_freq
);

  localparam int FW = speed_cmd_pkg::FREQ_W;
  localparam int HW = speed_cmd_pkg::HOLD_CNT_W;
  localparam int DW = speed_cmd_pkg::DWELL_CNT_W;
  localparam logic [HW-1:0] HOLD_LAST = HW'(speed_cmd_pkg::HOLD_TICKS - 1);
  localparam logic [DW-1:0] DWELL_UNIT = DW'(speed_cmd_pkg::DWELL_UNIT_TICKS);

  typedef struct packed {
    speed_cmd_pkg::run_state_e st;
    logic [FW-1:0] ud;
    logic [FW-1:0] saved;
    logic [FW-1:0] target;
    logic step_busy;
    logic up_prev;
    logic down_prev;
    logic clr_prev;
    logic run_prev;
    logic run_latch;
    logic [HW-1:0] hold_cnt;
    logic hold_long;
    logic [DW-1:0] dwell_cnt;
    logic [FW-1:0] freq_out;
    logic rev;
    logic dwell_out;
    logic run_out;
    logic jog_out;
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;

  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic tick;
  logic [speed_cmd_pkg::NUM_TERM*speed_cmd_pkg::FUNC_W-1:0] funcs;
  logic [3:0] term_lvl;
  logic fwd_lvl;
  logic fwd_rise;
  logic jog_lvl;
  logic jog_fwd_lvl;
  logic jog_rev_lvl;
  logic jog_any;
  logic up_lvl;
  logic down_lvl;
  logic clr_lvl;
  logic tw_assigned;
  logic tw_lvl;
  logic ud_selected;
  logic [FW-1:0] ud_hi;
  logic [FW-1:0] ud_lo;
  logic [DW-1:0] dwell_ticks;

  // True when a terminal carrying the code is at the given level set
  function automatic logic role_level(
    input logic [speed_cmd_pkg::NUM_TERM*speed_cmd_pkg::FUNC_W-1:0] fn,
    input logic [3:0] lvl,
    input logic [speed_cmd_pkg::FUNC_W-1:0] code
  );
    logic r;
    r = 1'b0;
    for (int i = 0; i < speed_cmd_pkg::NUM_TERM; i++)
    begin
      if (fn[i*speed_cmd_pkg::FUNC_W +: speed_cmd_pkg::FUNC_W] == code && lvl[i])
      begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // Bound a widened frequency between lo and hi
  function automatic logic [FW-1:0] clamp_freq(
    input logic [FW:0] v,
    input logic [FW-1:0] lo,
    input logic [FW-1:0] hi
  );
    logic [FW-1:0] r;
    if (v > {1'b0, hi})
    begin
      r = hi;
    end
    else if (v < {1'b0, lo})
    begin
      r = lo;
    end
    else
    begin
      r = v[FW-1:0];
    end
    return r;
  endfunction

  // Widened sum for upward moves
  function automatic logic [FW:0] add_freq(input logic [FW-1:0] a, input logic [FW-1:0] b);
    return {1'b0, a} + {1'b0, b};
  endfunction

  // Subtraction that floors at zero
  function automatic logic [FW:0] sub_freq(input logic [FW-1:0] a, input logic [FW-1:0] b);
    logic [FW:0] r;
    r = '0;
    if (a > b)
    begin
      r = {1'b0, a - b};
    end
    return r;
  endfunction

  // One ramp step from cur toward tgt, never passing it
  function automatic logic [FW-1:0] move_toward(
    input logic [FW-1:0] cur,
    input logic [FW-1:0] tgt,
    input logic [FW-1:0] rate
  );
    logic [FW-1:0] r;
    r = tgt;
    if (cur < tgt)
    begin
      r = clamp_freq(add_freq(cur, rate), FW'(0), tgt);
    end
    else if (cur > tgt)
    begin
      r = clamp_freq(sub_freq(cur, rate), tgt, cur);
    end
    return r;
  endfunction

  // Pin synchroniser for terminals and the run pin
  pin_sync_edge #(
    .N(5)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin_async({forward_run, input_terminal_4, input_terminal_3,
                input_terminal_2, input_terminal_1}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall()
  );

  // Millisecond enable for ramps, holds and dwell
  tick_divider #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // Terminal roles from the assigned function codes
  assign funcs = {terminal4_function, terminal3_function, terminal2_function, terminal1_function};
  assign term_lvl = pin_lvl[3:0];
  assign fwd_lvl = pin_lvl[4];
  assign fwd_rise = pin_rise[4];
  assign jog_lvl = role_level(funcs, term_lvl, speed_cmd_pkg::FN_JOG);
  assign jog_fwd_lvl = role_level(funcs, term_lvl, speed_cmd_pkg::FN_JOG_FWD);
  assign jog_rev_lvl = role_level(funcs, term_lvl, speed_cmd_pkg::FN_JOG_REV);
  assign jog_any = jog_lvl | jog_fwd_lvl | jog_rev_lvl;
  assign up_lvl = role_level(funcs, term_lvl, speed_cmd_pkg::FN_UP);
  assign down_lvl = role_level(funcs, term_lvl, speed_cmd_pkg::FN_DOWN);
  assign clr_lvl = role_level(funcs, term_lvl, speed_cmd_pkg::FN_UD_CLEAR);
  assign tw_assigned = role_level(funcs, 4'hf, speed_cmd_pkg::FN_THREE_WIRE);
  assign tw_lvl = role_level(funcs, term_lvl, speed_cmd_pkg::FN_THREE_WIRE);

  // Up/down source enable and its bounds
  assign ud_selected = (freq_setting_method == speed_cmd_pkg::METHOD_UPDOWN);
  assign ud_hi = freq_limit_enable ? freq_high_limit : max_freq_setting;
  assign ud_lo = freq_limit_enable ? freq_low_limit : FW'(0);
  assign dwell_ticks = DW'(dwell_time) * DWELL_UNIT;

  // Next-state logic for up/down, run latch, dwell and output
  always_comb
  begin
    logic run_req;
    logic up_rise;
    logic up_fall;
    logic down_rise;
    logic down_fall;
    logic continuous;
    logic [FW-1:0] f;
    run_req = 1'b0;
    up_rise = 1'b0;
    up_fall = 1'b0;
    down_rise = 1'b0;
    down_fall = 1'b0;
    continuous = 1'b0;
    f = FW'(0);
    d = q;

    // Role edges from registered samples
    up_rise = up_lvl & ~q.up_prev;
    up_fall = ~up_lvl & q.up_prev;
    down_rise = down_lvl & ~q.down_prev;
    down_fall = ~down_lvl & q.down_prev;
    d.up_prev = up_lvl;
    d.down_prev = down_lvl;
    d.clr_prev = clr_lvl;

    // Run request: latched push-button or plain level, jog also runs
    if (tw_assigned)
    begin
      if (fwd_rise)
      begin
        d.run_latch = 1'b1;
      end
      if (!tw_lvl)
      begin
        d.run_latch = 1'b0;
      end
    end
    else
    begin
      d.run_latch = fwd_lvl;
    end
    run_req = q.run_latch | jog_any;
    d.run_prev = run_req;

    // Long-hold timer restarts on any change of the up or down input
    if ((up_lvl != q.up_prev) || (down_lvl != q.down_prev))
    begin
      d.hold_cnt = '0;
      d.hold_long = 1'b0;
    end
    else if ((up_lvl || down_lvl) && tick && !q.hold_long)
    begin
      d.hold_cnt = q.hold_cnt + HW'(1);
      if (q.hold_cnt == HOLD_LAST)
      begin
        d.hold_long = 1'b1;
      end
    end

    continuous = (updown_mode_select == speed_cmd_pkg::UD_MODE_CONT) ||
                 ((updown_mode_select == speed_cmd_pkg::UD_MODE_COMBO) && q.hold_long);

    if (ud_selected)
    begin
      // Continuous ramp while held
      if (continuous)
      begin
        d.step_busy = 1'b0;
        if (tick && up_lvl && !down_lvl)
        begin
          d.ud = clamp_freq(add_freq(q.ud, updown_ramp_rate), FW'(0), ud_hi);
        end
        else if (tick && down_lvl && !up_lvl)
        begin
          d.ud = clamp_freq(sub_freq(q.ud, updown_ramp_rate), ud_lo, ud_hi);
        end
      end
      // Single steps on rising edges, ramped at the common rate
      else if (q.step_busy)
      begin
        if (tick)
        begin
          d.ud = move_toward(q.ud, q.target, updown_ramp_rate);
          if (d.ud == q.target)
          begin
            d.step_busy = 1'b0;
          end
        end
      end
      else if (up_rise)
      begin
        d.target = clamp_freq(add_freq(q.ud, updown_step_freq), FW'(0), ud_hi);
        d.step_busy = 1'b1;
      end
      else if (down_rise)
      begin
        d.target = clamp_freq(sub_freq(q.ud, updown_step_freq), ud_lo, ud_hi);
        d.step_busy = 1'b1;
      end

      // Restore the stored value at a run start
      if (run_req && !q.run_prev && updown_save_enable == speed_cmd_pkg::UD_SAVE_ON)
      begin
        d.ud = q.saved;
      end

      // Clear of the stored value, refused while up or down is held
      if (clr_lvl && !q.clr_prev && !up_lvl && !down_lvl)
      begin
        d.saved = speed_cmd_pkg::FREQ_ZERO;
        d.ud = speed_cmd_pkg::FREQ_ZERO;
      end

      // Save at release; save events win over a clear
      if (updown_save_enable == speed_cmd_pkg::UD_SAVE_ON)
      begin
        if (up_fall || down_fall)
        begin
          d.saved = q.ud;
        end
        else if (!run_req && q.run_prev &&
                 updown_mode_select != speed_cmd_pkg::UD_MODE_STEP)
        begin
          d.saved = q.ud;
        end
      end
    end

    // Run sequencing with dwell before acceleration
    case (q.st)
      speed_cmd_pkg::ST_STOP:
      begin
        d.dwell_cnt = '0;
        if (run_req)
        begin
          d.st = (dwell_ticks == '0) ? speed_cmd_pkg::ST_RUN : speed_cmd_pkg::ST_DWELL;
        end
      end
      speed_cmd_pkg::ST_DWELL:
      begin
        if (!run_req)
        begin
          d.st = speed_cmd_pkg::ST_STOP;
          d.dwell_cnt = '0;
        end
        else if (tick)
        begin
          d.dwell_cnt = q.dwell_cnt + DW'(1);
          if (q.dwell_cnt == dwell_ticks - DW'(1))
          begin
            d.st = speed_cmd_pkg::ST_RUN;
          end
        end
      end
      speed_cmd_pkg::ST_RUN:
      begin
        if (!run_req)
        begin
          d.st = speed_cmd_pkg::ST_STOP;
        end
      end
      default:
      begin
        d.st = speed_cmd_pkg::ST_STOP;
      end
    endcase

    // Source priority: dwell, jog, up/down, other reference
    if (d.st == speed_cmd_pkg::ST_STOP)
    begin
      f = speed_cmd_pkg::FREQ_ZERO;
    end
    else if (d.st == speed_cmd_pkg::ST_DWELL)
    begin
      f = dwell_freq;
    end
    else if (jog_any)
    begin
      f = clamp_freq({1'b0, jog_freq_setting}, start_freq_setting, max_freq_setting);
    end
    else if (ud_selected)
    begin
      f = q.ud;
    end
    else
    begin
      f = base_ref_freq;
    end

    // Final limits
    if (f > max_freq_setting)
    begin
      f = max_freq_setting;
    end
    if (f < start_freq_setting)
    begin
      f = speed_cmd_pkg::FREQ_ZERO;
    end

    d.freq_out = f;
    d.rev = jog_rev_lvl && !jog_fwd_lvl && !jog_lvl && (d.st == speed_cmd_pkg::ST_RUN);
    d.dwell_out = (d.st == speed_cmd_pkg::ST_DWELL);
    d.run_out = (d.st != speed_cmd_pkg::ST_STOP);
    d.jog_out = jog_any && (d.st == speed_cmd_pkg::ST_RUN);
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign freq_command = q.freq_out;
  assign reverse_dir = q.rev;
  assign run_active = q.run_out;
  assign dwell_active = q.dwell_out;
  assign jog_active = q.jog_out;
  assign updown_freq = q.ud;
  assign updown_saved_freq = q.saved;

endmodule

`default_nettype wire

/* drive_speed_command_select_tb_top.sv */
// Self-checking bench for the speed command selector
`timescale 1ns/1ps
`default_nettype none
module drive_speed_command_select_tb_top;
  localparam int T = 8;
  localparam int S = 6 * T;
  logic clk;
  logic arst_n;
  logic input_terminal_1, input_terminal_2, input_terminal_3, input_terminal_4, forward_run;
  logic [4:0] terminal1_function, terminal2_function, terminal3_function, terminal4_function;
  logic [3:0] freq_setting_method;
  logic [15:0] base_ref_freq, jog_freq_setting, max_freq_setting, start_freq_setting;
  logic [15:0] freq_high_limit, freq_low_limit, updown_step_freq, updown_ramp_rate, dwell_freq;
  logic freq_limit_enable, updown_save_enable;
  logic [1:0] updown_mode_select;
  logic [6:0] dwell_time;
  logic [15:0] freq_command, updown_freq, updown_saved_freq;
  logic reverse_dir, run_active, dwell_active, jog_active;
  logic [15:0] bases [3] = '{16'h0bb8, 16'h1770, 16'h0014};
  logic [15:0] limited [3] = '{16'h0bb8, 16'h1388, 16'h0000};
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  drive_speed_command_select #(.TICK_CYCLES(T)) drive_speed_command_select_inst (
    .clk, .arst_n, .input_terminal_1, .input_terminal_2, .input_terminal_3,
    .input_terminal_4, .forward_run, .terminal1_function, .terminal2_function,
    .terminal3_function, .terminal4_function, .freq_setting_method, .base_ref_freq,
    .jog_freq_setting, .max_freq_setting, .start_freq_setting, .freq_limit_enable,
    .freq_high_limit, .freq_low_limit, .updown_save_enable, .updown_mode_select,
    .updown_step_freq, .updown_ramp_rate, .dwell_freq, .dwell_time, .freq_command,
    .reverse_dir, .run_active, .dwell_active, .jog_active, .updown_freq, .updown_saved_freq
  );

  operator_panel #(.PULSE_CYC(50 * T)) operator_panel_inst (
    .clk, .input_terminal_1, .input_terminal_2, .input_terminal_3, .input_terminal_4,
    .forward_run
  );

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Set a contact
  task automatic pin(input int idx, input logic v);
    operator_panel_inst.drive(idx, v);
    cyc(S);
  endtask

  // Press and release
  task automatic tap(input int idx, input int gap);
    operator_panel_inst.drive(idx, 1'b1);
    cyc(gap);
    operator_panel_inst.drive(idx, 1'b0);
    cyc(gap);
  endtask

  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    terminal1_function = speed_cmd_pkg::FN_JOG;
    terminal2_function = speed_cmd_pkg::FN_UD_CLEAR;
    terminal3_function = speed_cmd_pkg::FN_UP;
    terminal4_function = speed_cmd_pkg::FN_DOWN;
    freq_setting_method = 4'h0;
    base_ref_freq = 16'h0bb8;
    jog_freq_setting = 16'h03e8;
    max_freq_setting = 16'h1388;
    start_freq_setting = 16'h0032;
    freq_limit_enable = 1'b0;
    freq_high_limit = 16'h0fa0;
    freq_low_limit = 16'h00c8;
    updown_save_enable = speed_cmd_pkg::UD_SAVE_ON;
    updown_mode_select = speed_cmd_pkg::UD_MODE_STEP;
    updown_step_freq = 16'h012c;
    updown_ramp_rate = 16'h03e8;
    dwell_freq = speed_cmd_pkg::DWELL_FREQ_DEFAULT;
    dwell_time = speed_cmd_pkg::DWELL_TIME_DEFAULT;
    cyc(8);
    arst_n <= 1'b1;
    // Base through final limits
    pin(4, 1'b1);
    foreach (bases[i])
    begin
      base_ref_freq <= bases[i];
      cyc(S);
      check(freq_command, limited[i]);
    end
    // Jog overrides and is clamped
    pin(0, 1'b1);
    check(freq_command, 16'h03e8);
    check(16'(jog_active), 16'h0001);
    jog_freq_setting <= 16'h2328;
    cyc(S);
    check(freq_command, 16'h1388);
    jog_freq_setting <= 16'h0014;
    cyc(S);
    check(freq_command, 16'h0032);
    jog_freq_setting <= 16'h03e8;
    pin(0, 1'b0);
    pin(4, 1'b0);
    // Directional jog
    terminal3_function <= speed_cmd_pkg::FN_JOG_FWD;
    terminal4_function <= speed_cmd_pkg::FN_JOG_REV;
    for (int i = 2; i < 4; i++)
    begin
      pin(i, 1'b1);
      check(freq_command, 16'h03e8);
      check(16'(reverse_dir), 16'(i == 3));
      pin(i, 1'b0);
      check(16'(run_active), 16'h0000);
    end
    // Step mode, gated by method
    terminal3_function <= speed_cmd_pkg::FN_UP;
    terminal4_function <= speed_cmd_pkg::FN_DOWN;
    pin(4, 1'b1);
    tap(2, S);
    check(updown_freq, 16'h0000);
    freq_setting_method <= speed_cmd_pkg::METHOD_UPDOWN;
    tap(2, S);
    tap(2, S);
    tap(3, S);
    check(updown_freq, 16'h012c);
    check(freq_command, 16'h012c);
    check(updown_saved_freq, 16'h012c);
    // Clear refused while up held
    pin(2, 1'b1);
    tap(1, S);
    check(updown_saved_freq, 16'h012c);
    check(updown_freq, 16'h0258);
    pin(2, 1'b0);
    check(updown_saved_freq, 16'h0258);
    tap(1, S);
    check(updown_saved_freq, 16'h0000);
    check(updown_freq, 16'h0000);
    // Second edge during a slow step
    updown_ramp_rate <= 16'h000a;
    tap(2, 4);
    tap(2, 4);
    cyc(50 * T);
    check(updown_freq, 16'h012c);
    pin(4, 1'b0);
    check(16'(updown_saved_freq != 16'h012c), 16'h0001);
    // Continuous mode
    updown_ramp_rate <= 16'h03e8;
    updown_mode_select <= speed_cmd_pkg::UD_MODE_CONT;
    pin(4, 1'b1);
    pin(2, 1'b1);
    cyc(S);
    check(updown_freq, 16'h1388);
    pin(2, 1'b0);
    freq_limit_enable <= 1'b1;
    pin(3, 1'b1);
    cyc(S);
    check(updown_freq, 16'h00c8);
    pin(3, 1'b0);
    pin(2, 1'b1);
    cyc(S);
    check(updown_freq, 16'h0fa0);
    pin(2, 1'b0);
    // Combined mode: step, then ramp
    updown_mode_select <= speed_cmd_pkg::UD_MODE_COMBO;
    updown_ramp_rate <= 16'h0064;
    pin(3, 1'b1);
    cyc(2900 * T);
    check(updown_freq, 16'h0e74);
    cyc(200 * T);
    check(updown_freq, 16'h00c8);
    pin(3, 1'b0);
    pin(4, 1'b0);
    // Dwell holds even against jog
    freq_setting_method <= 4'h0;
    dwell_time <= 7'h01;
    pin(4, 1'b1);
    check(16'(dwell_active), 16'h0001);
    pin(0, 1'b1);
    check(freq_command, 16'h01f4);
    cyc(100 * T);
    check(16'(dwell_active), 16'h0000);
    check(freq_command, 16'h03e8);
    pin(0, 1'b0);
    pin(4, 1'b0);
    dwell_time <= 7'h00;
    // Three-wire latch and stop
    terminal4_function <= speed_cmd_pkg::FN_THREE_WIRE;
    pin(3, 1'b1);
    operator_panel_inst.pulse(4);
    cyc(S);
    check(16'(run_active), 16'h0001);
    pin(3, 1'b0);
    check(16'(run_active), 16'h0000);
    pin(3, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire

/* operator_panel.sv */
// Operator panel model: switches and push-buttons on the terminal pins
`timescale 1ns/1ps
`default_nettype none
module operator_panel #(
  parameter int PULSE_CYC = 400
) (
  input wire logic clk,
  output logic input_terminal_1,
  output logic input_terminal_2,
  output logic input_terminal_3,
  output logic input_terminal_4,
  output logic forward_run
);
  logic [4:0] pins_q = 5'h00;

  // Contacts straight onto the pins
  assign {forward_run, input_terminal_4, input_terminal_3, input_terminal_2,
    input_terminal_1} = pins_q;

  // Contact change just after a rising edge
  task automatic drive(input int idx, input logic v);
    @(posedge clk);
    pins_q[idx] <= v;
  endtask

  // Push-button press held for the minimum width
  task automatic pulse(input int idx);
    drive(idx, 1'b1);
    repeat (PULSE_CYC) @(posedge clk);
    drive(idx, 1'b0);
  endtask
endmodule
`default_nettype wire

/* pin_sync_edge.sv */
// Two-flop synchroniser with registered edge detection for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync_edge #(
  parameter int N = 5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [N-1:0] pin_async,
  output logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;
  } sync_s;

  sync_s q;
  sync_s d;

  // Next stage values; first stage feeds only the second
  always_comb
  begin
    d = q;
    d.meta = pin_async;
    d.sync = q.meta;
    d.prev = q.sync;
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Edges from two registered samples
  assign level = q.sync;
  assign rise = q.sync & ~q.prev;
  assign fall = ~q.sync & q.prev;

endmodule

`default_nettype wire

/* speed_cmd_monitor.sv */
// Checker of output relations for the speed command selector
`timescale 1ns/1ps
`default_nettype none
module speed_cmd_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic input_terminal_4,
  input wire logic [4:0] terminal4_function,
  input wire logic [3:0] freq_setting_method,
  input wire logic [15:0] jog_freq_setting,
  input wire logic [15:0] max_freq_setting,
  input wire logic [15:0] start_freq_setting,
  input wire logic [1:0] updown_mode_select,
  input wire logic [15:0] updown_step_freq,
  input wire logic [15:0] updown_ramp_rate,
  input wire logic [15:0] dwell_freq,
  input wire logic [15:0] freq_command,
  input wire logic reverse_dir,
  input wire logic run_active,
  input wire logic dwell_active,
  input wire logic jog_active,
  input wire logic [15:0] updown_freq
);
  logic [63:0] cfg;
  logic [63:0] cfg_q;
  logic cfg_ok;
  logic [15:0] jog_exp;

  // Final limits
  function automatic logic [15:0] lim(input logic [15:0] v);
    if (v > max_freq_setting)
      return max_freq_setting;
    return (v < start_freq_setting) ? 16'h0000 : v;
  endfunction

  // Settings steady
  assign cfg = {max_freq_setting, start_freq_setting, jog_freq_setting, dwell_freq};
  always_ff @(posedge clk)
    cfg_q <= cfg;
  assign cfg_ok = cfg_q == cfg;
  assign jog_exp = (jog_freq_setting < start_freq_setting) ? start_freq_setting
    : lim(jog_freq_setting);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Steady windows
  sequence cfg_still;
    cfg_ok[*4];
  endsequence
  sequence jog_still;
    (jog_active && cfg_ok)[*4];
  endsequence
  sequence dwell_still;
    (dwell_active && cfg_ok)[*4];
  endsequence
  sequence run_still;
    run_active && $past(run_active) && $past(run_active, 2);
  endsequence

  dwell_in_run_a:
    assert property (dwell_active |-> run_active) else $error("dwell outside run");
  dwell_level_a:
    assert property (dwell_still |-> freq_command == lim(dwell_freq))
      else $error("dwell output wrong");
  jog_in_run_a:
    assert property (jog_active |-> run_active) else $error("jog outside run");
  jog_level_a:
    assert property (jog_still |-> freq_command == jog_exp) else $error("jog output wrong");
  rev_jog_a:
    assert property (reverse_dir |-> jog_active) else $error("reverse without jog");
  max_cap_a:
    assert property (cfg_still |-> freq_command <= max_freq_setting) else $error("above max");
  start_floor_a:
    assert property (cfg_still |-> freq_command == 16'h0000 || freq_command >= start_freq_setting)
      else $error("below start");
  stop_button_a:
    assert property ((terminal4_function == speed_cmd_pkg::FN_THREE_WIRE
      && !input_terminal_4)[*5] |-> !run_active) else $error("run kept with stop low");
  ramp_bound_a:
    assert property (run_still |-> updown_freq
      <= 17'($past(updown_freq)) + updown_ramp_rate) else $error("ramp too fast");
  step_bound_a:
    assert property (run_still ##0 updown_mode_select == speed_cmd_pkg::UD_MODE_STEP
      |-> updown_freq <= 17'($past(updown_freq)) + updown_step_freq)
      else $error("step too large");
  method_gate_a:
    assert property (run_still ##0 (freq_setting_method != speed_cmd_pkg::METHOD_UPDOWN
      && $past(freq_setting_method) != speed_cmd_pkg::METHOD_UPDOWN)
      |-> updown_freq <= $past(updown_freq)) else $error("up/down off but rising");
endmodule

bind drive_speed_command_select speed_cmd_monitor speed_cmd_monitor_inst (.*);
`default_nettype wire

/* speed_cmd_pkg.sv */
// Shared constants and types for the speed command selector
package speed_cmd_pkg;

  // Data widths
  localparam int FREQ_W = 16;
  localparam int FUNC_W = 5;
  localparam int NUM_TERM = 4;
  localparam int DWELL_TIME_W = 7;

  // Terminal function codes
  localparam logic [FUNC_W-1:0] FN_JOG = 5'h04;
  localparam logic [FUNC_W-1:0] FN_UP = 5'h0f;
  localparam logic [FUNC_W-1:0] FN_DOWN = 5'h10;
  localparam logic [FUNC_W-1:0] FN_THREE_WIRE = 5'h11;
  localparam logic [FUNC_W-1:0] FN_UD_CLEAR = 5'h19;
  localparam logic [FUNC_W-1:0] FN_JOG_FWD = 5'h1a;
  localparam logic [FUNC_W-1:0] FN_JOG_REV = 5'h1b;

  // Frequency setting method and up/down modes
  localparam logic [3:0] METHOD_UPDOWN = 4'h8;
  localparam logic [1:0] UD_MODE_CONT = 2'h0;
  localparam logic [1:0] UD_MODE_STEP = 2'h1;
  localparam logic [1:0] UD_MODE_COMBO = 2'h2;
  localparam logic UD_SAVE_ON = 1'b1;

  // Values after reset and documented defaults, frequency in 0.01 Hz
  localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;
  localparam logic [FREQ_W-1:0] DWELL_FREQ_DEFAULT = 16'h01f4;
  localparam logic [DWELL_TIME_W-1:0] DWELL_TIME_DEFAULT = 7'h00;

  // Timing: clock rate, base tick, long hold and dwell unit
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int TICK_TIME_MS = 1;
  localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1000) * TICK_TIME_MS;
  localparam int HOLD_TIME_S = 3;
  localparam int HOLD_TICKS = (HOLD_TIME_S * 1000) / TICK_TIME_MS;
  localparam int HOLD_CNT_W = 12;
  localparam int DWELL_UNIT_MS = 100;
  localparam int DWELL_UNIT_TICKS = DWELL_UNIT_MS / TICK_TIME_MS;
  localparam int DWELL_CNT_W = 14;
  localparam int PULSE_MIN_MS = 50;

  // Run sequencing states
  typedef enum logic [1:0] {ST_STOP, ST_DWELL, ST_RUN} run_state_e;

endpackage

/* tick_divider.sv */
// Divider giving a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
  parameter int CYCLES = 40000
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic tick
);

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } div_s;

  div_s q;
  div_s d;

  // Count and wrap
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == LAST)
    begin
      d.cnt = '0;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

`default_nettype wire
